// >>> core/psalu_defines.svh
`ifndef PSALU_DEFINES_SVH
`define PSALU_DEFINES_SVH

// Register indices that must never appear in these operations
`define PSALU_REG_STACK_PTR 4'hD
`define PSALU_REG_PROG_CTR  4'hF

// Lane widths
`define PSALU_HALF_W      16
`define PSALU_BYTE_W      8

// Reset values
`define PSALU_FLAGS_RESET 4'h0
`define PSALU_INDEX_RESET 4'h0
`define PSALU_DATA_RESET  32'h0000_0000

// Bit positions of the packed flag output
`define PSALU_FLAG_N      3
`define PSALU_FLAG_Z      2
`define PSALU_FLAG_C      1
`define PSALU_FLAG_V      0

`endif

// >>> core/psalu_pkg.sv
package psalu_pkg;

  // Operations executed by this slice
  typedef enum logic [3:0] {
    PSALU_OP_NONE,
    PSALU_OP_UHW_ADD,
    PSALU_OP_UBYTE_ADD,
    PSALU_OP_UHALVE_HW_ADD,
    PSALU_OP_UHALVE_BYTE_ADD,
    PSALU_OP_U_ADD_SUB_X,
    PSALU_OP_U_SUB_ADD_X,
    PSALU_OP_S_ADD_SUB_X,
    PSALU_OP_S_SUB_ADD_X,
    PSALU_OP_BIT_TEST,
    PSALU_OP_EQUIV_TEST
  } psalu_op_t;

  // Whole registered state of the datapath slice
  typedef struct packed {
    logic        wb_valid;
    logic [3:0]  wb_index;
    logic [31:0] wb_data;
    logic [3:0]  flags;
    logic        op_done;
    logic        illegal_reg;
  } psalu_state_t;

endpackage : psalu_pkg

// >>> core/psalu_top.sv
`timescale 1ns/1ps
`include "psalu_defines.svh"
// Summary of operation
// RQ1: Signed add-sub-exchange puts first.hi plus second.lo in upper half.
// RQ2: Signed add-sub-exchange puts the halfword difference in lower half.
// RQ3: Signed sub-add-exchange: sum in lower half, difference in upper half.
// RQ4: Signed exchange variants pair halves exactly like the unsigned ones.
// RQ5: All four exchange operations leave the condition flags untouched.
// RQ6: Bit test ANDs the operands, updates flags, writes no register.
// RQ7: Equivalence test XORs the operands, updates flags, writes no register.
// RQ8: Both tests set N and Z from the 32-bit result, keep V.
// RQ9: Tests change carry only from the second operand shifter carry-out.
// RQ10: Halfword add does two independent 16-bit sums into matching halves.
// RQ11: Byte add does four independent 8-bit sums into matching bytes.
// RQ12: Lane adds and halving adds leave the condition flags untouched.
// RQ13: Unsigned add-sub-exchange: first.lo minus second.hi to lower half.
// RQ14: Unsigned add-sub-exchange: first.hi plus second.lo to upper half.
// RQ15: Unsigned sub-add-exchange: first.lo plus second.hi to lower half.
// RQ16: Unsigned sub-add-exchange: first.hi minus second.lo to upper half.
// RQ17: Halving halfword add halves each halfword sum by a right shift.
// RQ18: Halving byte add halves each byte sum by a right shift.
// RQ19: Lane carry-out becomes the top bit after halving, so nothing wraps.
// RQ20: The issuer never names stack pointer or program counter here.
// RQ21: With no destination given, the result goes back to the first source.
// RQ22: A failed condition suppresses both register write and flag update.

module psalu_top (
  input  wire logic              clock,          // Core clock, 250 MHz
  input  wire logic              reset_n,        // Async reset, active low
  input  wire logic              op_valid,       // Operation issued this cycle
  input  wire psalu_pkg::psalu_op_t op_code,     // Operation selector
  input  wire logic              cond_pass,      // Condition code true
  input  wire logic [31:0]       first_source,   // First source data
  input  wire logic [31:0]       second_source,  // Second source or shifted operand
  input  wire logic [3:0]        first_index,    // First source register
  input  wire logic [3:0]        second_index,   // Second source register
  input  wire logic              second_is_reg,  // Second operand is a reg
  input  wire logic [3:0]        dest_index,     // Destination register
  input  wire logic              dest_given,     // Destination field present
  input  wire logic              shift_carry_vld,// Shifter produced a carry
  input  wire logic              shift_carry,    // Shifter carry-out
  output logic                   wb_valid,       // Register write strobe
  output logic [3:0]             wb_index,       // Register to write
  output logic [31:0]            wb_data,        // Value to write
  output logic [3:0]             flags,          // N Z C V, held
  output logic                   op_done,        // Operation retired pulse
  output logic                   illegal_reg     // Forbidden register named
);

  psalu_pkg::psalu_state_t state;
  psalu_pkg::psalu_state_t next_state;

  logic reset_meta_n;
  logic reset_sync_n;

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end
    else
    begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // One halfword lane, optionally halved; carry kept as the new top bit
  function automatic logic [15:0] psalu_hw_add(
    input logic [15:0] a,
    input logic [15:0] b,
    input logic        halve
  );
    logic [16:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    psalu_hw_add = halve ? sum[16:1] : sum[15:0]; // RQ19
  endfunction : psalu_hw_add

  // One byte lane, same treatment as the halfword lane
  function automatic logic [7:0] psalu_byte_add(
    input logic [7:0] a,
    input logic [7:0] b,
    input logic       halve
  );
    logic [8:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    psalu_byte_add = halve ? sum[8:1] : sum[7:0]; // RQ19
  endfunction : psalu_byte_add

  // True when an index is one of the two forbidden registers
  function automatic logic psalu_forbidden(input logic [3:0] idx);
    psalu_forbidden = (idx == `PSALU_REG_STACK_PTR) ||
                      (idx == `PSALU_REG_PROG_CTR);
  endfunction : psalu_forbidden

  logic [15:0] a_hi;
  logic [15:0] a_lo;
  logic [15:0] b_hi;
  logic [15:0] b_lo;

  assign a_hi = first_source[31:16];
  assign a_lo = first_source[15:0];
  assign b_hi = second_source[31:16];
  assign b_lo = second_source[15:0];

  // Decode, compute and choose the next state
  always_comb
  begin
    logic        is_test;
    logic        halve;
    logic [3:0]  target;
    logic        bad;
    logic [31:0] lanes;
    logic [31:0] logic_res;
    next_state = state;
    is_test = (op_code == psalu_pkg::PSALU_OP_BIT_TEST) ||
              (op_code == psalu_pkg::PSALU_OP_EQUIV_TEST);
    halve = (op_code == psalu_pkg::PSALU_OP_UHALVE_HW_ADD) ||
            (op_code == psalu_pkg::PSALU_OP_UHALVE_BYTE_ADD);
    target = dest_given ? dest_index : first_index; // RQ21
    // Forbidden registers make the operation do nothing
    bad = psalu_forbidden(first_index) ||
          (second_is_reg && psalu_forbidden(second_index)) ||
          (!is_test && psalu_forbidden(target)); // RQ20
    lanes = `PSALU_DATA_RESET;
    logic_res = `PSALU_DATA_RESET;
    next_state.wb_valid = 1'b0;
    next_state.op_done = op_valid;
    next_state.illegal_reg = op_valid && bad;
    case (op_code)
      psalu_pkg::PSALU_OP_UHW_ADD,
      psalu_pkg::PSALU_OP_UHALVE_HW_ADD:
      begin
        lanes = {psalu_hw_add(a_hi, b_hi, halve),
                 psalu_hw_add(a_lo, b_lo, halve)}; // RQ10 RQ17
      end
      psalu_pkg::PSALU_OP_UBYTE_ADD,
      psalu_pkg::PSALU_OP_UHALVE_BYTE_ADD:
      begin
        for (int i = 0; i < 4; i++)
        begin
          lanes[i*8 +: 8] = psalu_byte_add(first_source[i*8 +: 8],
                                           second_source[i*8 +: 8],
                                           halve); // RQ11 RQ18
        end
      end
      // Signed and unsigned wrap identically at 16 bits
      psalu_pkg::PSALU_OP_U_ADD_SUB_X,
      psalu_pkg::PSALU_OP_S_ADD_SUB_X:
      begin
        lanes[31:16] = a_hi + b_lo; // RQ1 RQ14 RQ4
        lanes[15:0]  = a_lo - b_hi; // RQ2 RQ13 RQ4
      end
      psalu_pkg::PSALU_OP_U_SUB_ADD_X,
      psalu_pkg::PSALU_OP_S_SUB_ADD_X:
      begin
        lanes[15:0]  = a_lo + b_hi; // RQ3 RQ15 RQ4
        lanes[31:16] = a_hi - b_lo; // RQ3 RQ16 RQ4
      end
      psalu_pkg::PSALU_OP_BIT_TEST:
      begin
        logic_res = first_source & second_source; // RQ6
      end
      psalu_pkg::PSALU_OP_EQUIV_TEST:
      begin
        logic_res = first_source ^ second_source; // RQ7
      end
      default:
      begin
        lanes = `PSALU_DATA_RESET;
      end
    endcase
    // Only a passed, legal operation has any architectural effect
    if (op_valid && cond_pass && !bad &&
        op_code != psalu_pkg::PSALU_OP_NONE) // RQ22
    begin
      if (is_test)
      begin
        // Flags only; V is never touched here
        next_state.flags[`PSALU_FLAG_N] = logic_res[31]; // RQ8
        next_state.flags[`PSALU_FLAG_Z] = (logic_res == 32'h0); // RQ8
        if (shift_carry_vld)
        begin
          next_state.flags[`PSALU_FLAG_C] = shift_carry; // RQ9
        end
      end
      else
      begin
        // Packed operations write back and keep flags as they are
        next_state.wb_valid = 1'b1; // RQ5 RQ12
        next_state.wb_index = target;
        next_state.wb_data = lanes;
      end
    end
  end

  // Single state register
  always_ff @(posedge clock or negedge reset_sync_n)
  begin
    if (!reset_sync_n)
    begin
      state.wb_valid <= 1'b0;
      state.wb_index <= `PSALU_INDEX_RESET;
      state.wb_data <= `PSALU_DATA_RESET;
      state.flags <= `PSALU_FLAGS_RESET;
      state.op_done <= 1'b0;
      state.illegal_reg <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state flops
  assign wb_valid = state.wb_valid;
  assign wb_index = state.wb_index;
  assign wb_data = state.wb_data;
  assign flags = state.flags;
  assign op_done = state.op_done;
  assign illegal_reg = state.illegal_reg;

  // Issue qualifier used by the checks below
  logic go;
  assign go = op_valid && cond_pass && !next_state.illegal_reg &&
              op_code != psalu_pkg::PSALU_OP_NONE;

  default clocking psalu_cb @(posedge clock);
  endclocking
  default disable iff (!reset_sync_n);

  property p_s_addsub_hi;
    go && op_code == psalu_pkg::PSALU_OP_S_ADD_SUB_X |=>
      wb_valid && wb_data[31:16] ==
      16'($past(first_source[31:16]) + $past(second_source[15:0]));
  endproperty
  a_s_addsub_hi: assert property (p_s_addsub_hi) // RQ1
    else $error("signed add-sub-exchange upper half wrong");

  property p_s_addsub_lo;
    go && op_code == psalu_pkg::PSALU_OP_S_ADD_SUB_X |=>
      wb_data[15:0] ==
      16'($past(first_source[15:0]) - $past(second_source[31:16]));
  endproperty
  a_s_addsub_lo: assert property (p_s_addsub_lo) // RQ2
    else $error("signed add-sub-exchange lower half wrong");

  property p_s_subadd;
    go && op_code == psalu_pkg::PSALU_OP_S_SUB_ADD_X |=>
      wb_data == {16'($past(first_source[31:16]) -
                      $past(second_source[15:0])),
                  16'($past(first_source[15:0]) +
                      $past(second_source[31:16]))};
  endproperty
  a_s_subadd: assert property (p_s_subadd) // RQ3
    else $error("signed sub-add-exchange result wrong");

  // Unsigned exchange pairs are checked whole, both halves at once
  property p_u_addsub;
    go && op_code == psalu_pkg::PSALU_OP_U_ADD_SUB_X |=>
      wb_data == {16'($past(first_source[31:16]) +
                      $past(second_source[15:0])),
                  16'($past(first_source[15:0]) -
                      $past(second_source[31:16]))};
  endproperty
  a_u_addsub: assert property (p_u_addsub) // RQ13 RQ14
    else $error("unsigned add-sub-exchange result wrong");

  property p_u_subadd;
    go && op_code == psalu_pkg::PSALU_OP_U_SUB_ADD_X |=>
      wb_data == {16'($past(first_source[31:16]) -
                      $past(second_source[15:0])),
                  16'($past(first_source[15:0]) +
                      $past(second_source[31:16]))};
  endproperty
  a_u_subadd: assert property (p_u_subadd) // RQ15 RQ16
    else $error("unsigned sub-add-exchange result wrong");

  // Outer byte lanes catch a carry leaking from the third byte lane into the top one
  property p_byte_add;
    go && op_code == psalu_pkg::PSALU_OP_UBYTE_ADD |=>
      wb_data[31:24] ==
      8'($past(first_source[31:24]) + $past(second_source[31:24])) &&
      wb_data[7:0] ==
      8'($past(first_source[7:0]) + $past(second_source[7:0]));
  endproperty
  a_byte_add: assert property (p_byte_add) // RQ11
    else $error("byte lane add result wrong");

  property p_bit_test_nz;
    go && op_code == psalu_pkg::PSALU_OP_BIT_TEST |=>
      flags[`PSALU_FLAG_Z] == (($past(first_source) &
                                $past(second_source)) == 32'h0)
      && flags[`PSALU_FLAG_N] ==
         ($past(first_source[31]) & $past(second_source[31]));
  endproperty
  a_bit_test_nz: assert property (p_bit_test_nz) // RQ6 RQ8
    else $error("bit test N or Z wrong");

  property p_packed_flags;
    go && op_code != psalu_pkg::PSALU_OP_BIT_TEST &&
    op_code != psalu_pkg::PSALU_OP_EQUIV_TEST |=> $stable(flags);
  endproperty
  a_packed_flags: assert property (p_packed_flags) // RQ5 RQ12
    else $error("packed operation changed the flags");

  property p_test_nowrite;
    op_valid && (op_code == psalu_pkg::PSALU_OP_BIT_TEST ||
                 op_code == psalu_pkg::PSALU_OP_EQUIV_TEST) |=> !wb_valid;
  endproperty
  a_test_nowrite: assert property (p_test_nowrite) // RQ6
    else $error("test operation wrote a register");

  property p_test_nz;
    go && op_code == psalu_pkg::PSALU_OP_EQUIV_TEST |=>
      flags[`PSALU_FLAG_Z] == ($past(first_source) == $past(second_source))
      && flags[`PSALU_FLAG_N] ==
         ($past(first_source[31]) ^ $past(second_source[31]));
  endproperty
  a_test_nz: assert property (p_test_nz) // RQ8
    else $error("equivalence test N or Z wrong");

  property p_v_kept;
    ##1 $stable(flags[`PSALU_FLAG_V]);
  endproperty
  a_v_kept: assert property (p_v_kept) // RQ8
    else $error("overflow flag changed");

  property p_carry_src;
    !(op_valid && shift_carry_vld) |=> $stable(flags[`PSALU_FLAG_C]);
  endproperty
  a_carry_src: assert property (p_carry_src) // RQ9
    else $error("carry changed without shifter carry");

  property p_halve_hw;
    go && op_code == psalu_pkg::PSALU_OP_UHALVE_HW_ADD |=>
      wb_data[15:0] == 16'((17'($past(first_source[15:0])) +
                           17'($past(second_source[15:0]))) >> 1);
  endproperty
  a_halve_hw: assert property (p_halve_hw) // RQ19
    else $error("halving add lost the lane carry");

  property p_dest_default;
    go && !dest_given && op_code == psalu_pkg::PSALU_OP_UBYTE_ADD |=>
      wb_valid && wb_index == $past(first_index);
  endproperty
  a_dest_default: assert property (p_dest_default) // RQ21
    else $error("missing destination not taken from first source");

  property p_cond_fail;
    op_valid && !cond_pass |=> !wb_valid && $stable(flags);
  endproperty
  a_cond_fail: assert property (p_cond_fail) // RQ22
    else $error("failed condition still had an effect");

  c_uhw: cover property (go && op_code == psalu_pkg::PSALU_OP_UHW_ADD
                         ##1 wb_valid);
  c_bit_test: cover property (go && op_code == psalu_pkg::PSALU_OP_BIT_TEST
                         && shift_carry_vld ##1 flags[`PSALU_FLAG_Z]);
  c_fail: cover property (op_valid && !cond_pass ##1 op_done);
  c_bad: cover property (illegal_reg);

endmodule : psalu_top

// >>> verification/packed_simd_alu_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin num_checks++; if ((g) !== (e)) \
  begin n_fail++; $display("BAD %0t output differs", $time); end end
module packed_simd_alu_tb;
  typedef struct packed {
    logic        wr;
    logic [3:0]  idx;
    logic [31:0] dat;
    logic [3:0]  fl;
  } psalu_exp_t;
  logic                 clock;
  logic                 reset_n;
  psalu_pkg::psalu_op_t op;
  logic                 vld, cp, sr, dg, cv, c, wb_valid, op_done;
  logic                 illegal_reg;
  logic [31:0]          a, b, wb_data;
  logic [3:0]           fi, si, di, wb_index, flags, mfl;
  int                   n_fail, num_checks;
  psalu_exp_t           expq[$];
  psalu_exp_t           e;
  logic [31:0] av [4] = '{32'hFFFF_FFFF, 32'h8000_7FFF, 32'h0, 32'h1234_8001};
  logic [31:0] bv [4] = '{32'hFFFF_0001, 32'h8000_8001, 32'h0, 32'hEDCB_7FFE};

  psalu_issuer i_psalu_issuer (.clock(clock), .op(op), .vld(vld), .cp(cp),
    .a(a), .b(b), .fi(fi), .si(si), .sr(sr), .di(di), .dg(dg), .cv(cv),
    .c(c));

  psalu_top i_psalu_top (.clock(clock), .reset_n(reset_n), .op_valid(vld),
    .op_code(op), .cond_pass(cp), .first_source(a), .second_source(b),
    .first_index(fi), .second_index(si), .second_is_reg(sr),
    .dest_index(di), .dest_given(dg), .shift_carry_vld(cv),
    .shift_carry(c), .wb_valid(wb_valid), .wb_index(wb_index),
    .wb_data(wb_data), .flags(flags), .op_done(op_done),
    .illegal_reg(illegal_reg));

  // 250 MHz core clock
  initial clock = 1'b0;
  always #2 clock = ~clock;

  // Works out the expected result, notes it, then issues the operation
  task automatic run(input int k, input logic [31:0] x, input logic [31:0] y);
    psalu_exp_t           n;
    logic [16:0]          h;
    logic [8:0]           s;
    psalu_pkg::psalu_op_t o;
    logic [3:0]           f, d;
    logic                 p, g, v, q;
    o = psalu_pkg::psalu_op_t'(k);
    f = 4'($urandom_range(12));
    d = 4'($urandom_range(12));
    p = ($urandom_range(3) != 0);
    {g, v, q} = 3'($urandom);
    n.dat = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      s = {1'b0, x[8*i+:8]} + {1'b0, y[8*i+:8]};
      if (o == psalu_pkg::PSALU_OP_UBYTE_ADD)
        n.dat[8*i+:8] = s[7:0];
      if (o == psalu_pkg::PSALU_OP_UHALVE_BYTE_ADD)
        n.dat[8*i+:8] = s[8:1];
    end
    for (int i = 0; i < 2; i++)
    begin
      h = {1'b0, x[16*i+:16]} + {1'b0, y[16*i+:16]};
      if (o == psalu_pkg::PSALU_OP_UHW_ADD)
        n.dat[16*i+:16] = h[15:0];
      if (o == psalu_pkg::PSALU_OP_UHALVE_HW_ADD)
        n.dat[16*i+:16] = h[16:1];
    end
    case (o)
      psalu_pkg::PSALU_OP_U_ADD_SUB_X, psalu_pkg::PSALU_OP_S_ADD_SUB_X:
        n.dat = {x[31:16] + y[15:0],
                 x[15:0] - y[31:16]};
      psalu_pkg::PSALU_OP_U_SUB_ADD_X, psalu_pkg::PSALU_OP_S_SUB_ADD_X:
        n.dat = {x[31:16] - y[15:0],
                 x[15:0] + y[31:16]};
      psalu_pkg::PSALU_OP_BIT_TEST: n.dat = x & y;
      psalu_pkg::PSALU_OP_EQUIV_TEST: n.dat = x ^ y;
      default: ;
    endcase
    // Only tests that pass their condition touch the flags
    n.wr = p && o != psalu_pkg::PSALU_OP_NONE
      && o < psalu_pkg::PSALU_OP_BIT_TEST;
    if (p && o >= psalu_pkg::PSALU_OP_BIT_TEST)
    begin
      mfl[3] = n.dat[31];
      mfl[2] = (n.dat == 32'h0000_0000);
      if (v) mfl[1] = q;
    end
    n.fl = mfl;
    n.idx = g ? d : f;
    expq.push_back(n);
    i_psalu_issuer.issue(o, x, y, f, 4'($urandom_range(12)), d, g, p, v, q);
  endtask : run

  // Takes the oldest note whenever an operation retires
  always @(negedge clock)
  begin
    if (op_done === 1'b1)
    begin
      `CHK(expq.size() > 0, 1'b1)
      if (expq.size() > 0) e = expq.pop_front();
      `CHK(wb_valid, e.wr)
      `CHK(illegal_reg, 1'b0)
      if (e.wr) `CHK(wb_index, e.idx)
      if (e.wr) `CHK(wb_data, e.dat)
      `CHK(flags, e.fl)
    end
    else
      `CHK(wb_valid, 1'b0)
  end

  task automatic final_report();
    if (n_fail == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // Boundary operands back to back for every code, an idle cycle between codes, then random traffic
  initial
  begin
    reset_n = 1'b0;
    mfl = 4'h0;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(43355));
    repeat (10) @(negedge clock);
    `CHK(flags, 4'h0)
    reset_n = 1'b1;
    @(negedge clock);
    for (int k = 0; k <= 10; k++)
    begin
      foreach (av[j]) run(k, av[j], bv[j]);
      i_psalu_issuer.idle();
    end
    repeat (400) run($urandom_range(10), $urandom, $urandom);
    i_psalu_issuer.idle();
    for (int t = 0; t < 20 && expq.size() != 0; t++) @(negedge clock);
    `CHK(expq.size(), 0)
    final_report();
  end
endmodule : packed_simd_alu_tb

// >>> verification/psalu_issuer.sv
`timescale 1ns/1ps
`include "psalu_defines.svh"
// Issue stage model: one operation per call, driven on the falling edge
module psalu_issuer (
  input  wire logic            clock, // Core clock
  output psalu_pkg::psalu_op_t op,    // Operation
  output logic                 vld,   // Issue strobe
  output logic                 cp,    // Condition true
  output logic [31:0]          a,     // First operand
  output logic [31:0]          b,     // Second operand
  output logic [3:0]           fi,    // First register
  output logic [3:0]           si,    // Second register
  output logic                 sr,    // Second is a register
  output logic [3:0]           di,    // Destination
  output logic                 dg,    // Destination given
  output logic                 cv,    // Shifter carry valid
  output logic                 c      // Shifter carry
);
  // Quiet start so nothing is unknown at time zero
  initial
  begin
    op = psalu_pkg::PSALU_OP_NONE;
    {vld, cp, a, b, fi, si, sr, di, dg, cv, c} = '0;
  end

  // Never names the stack pointer or program counter
  function automatic logic [3:0] legal(input logic [3:0] r);
    return (r == `PSALU_REG_STACK_PTR || r == `PSALU_REG_PROG_CTR) ?
           4'h0 : r;
  endfunction : legal

  task automatic issue(input psalu_pkg::psalu_op_t o, input logic [31:0] x,
    input logic [31:0] y, input logic [3:0] f, input logic [3:0] s,
    input logic [3:0] d, input logic g, input logic p, input logic v,
    input logic k);
    @(negedge clock);
    vld = 1'b1;
    op = o;
    a = x;
    b = y;
    fi = legal(f);
    si = legal(s);
    sr = s[0];
    di = legal(d);
    {dg, cp, cv, c} = {g, p, v, k};
  endtask : issue

  // Released operand lines show inverted data, not the last value
  task automatic idle();
    @(negedge clock);
    vld = 1'b0;
    op = psalu_pkg::PSALU_OP_NONE;
    a = ~a;
    b = ~b;
  endtask : idle
endmodule : psalu_issuer
